/* hw/pplv_top.sv */
// Pin level registers of a 32-pin general purpose port.
// Assumes direction, function select, set and clear come from sibling registers.
// Function
// - Low half bit n is pin n, high half bit n is pin n+16.
// - Writing a level bit of a general output sets its driven level.
// - Separate set and clear strobes also change a general output level.
// - Reading a general output returns the level last programmed.
// - Reading a pin in interface function returns the live pin state.
// - A read reports the pin state for every pin that is not a general output.
// - Low half sits at offset C30h, high half at C32h.
// - A 32-bit access at C30h runs as two 16-bit accesses.
// - Low half goes first, high half second, not at one instant.
// - Direction 0 is input, 1 is output; output needed before level shows.
// - After reset every pin is an input with pull termination on.
// - Function select gives the pin its interface function, direction ignored.
// - A set strobe drives high and overrides a level or clear write in the same cycle.
`timescale 1ns/1ps

module pplv_top
	import pplv_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        reg_req,
	input  wire logic        reg_wr,
	input  wire logic [11:0] reg_addr,
	input  wire logic        reg_wide,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             reg_ack,
	input  wire logic [31:0] dir_bits,
	input  wire logic [31:0] func_bits,
	input  wire logic [31:0] drive_high_pulse,
	input  wire logic [31:0] drive_low_pulse,
	input  wire logic [31:0] alt_out,
	input  wire logic [31:0] alt_oe,
	input  wire logic [31:0] pin_in,
	output logic      [31:0] pin_out,
	output logic      [31:0] pin_oe,
	output logic      [31:0] pull_en
);

	pplv_half_s  half;
	logic [31:0] level_r;
	logic [31:0] level_nxt;
	logic [31:0] pin_meta_r;
	logic [31:0] pin_sync_r;
	logic [31:0] pin_out_r;
	logic [31:0] pin_out_nxt;
	logic [31:0] pin_oe_r;
	logic [31:0] pin_oe_nxt;
	logic [31:0] pull_en_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        ack_r;
	logic [31:0] gpo;
	logic [31:0] bus_wr_bit;
	logic [31:0] read_all;

	// Request splitting lives in its own module so the sequencing stays small
	pplv_split u_split (
		.clk   (clk),
		.reset (reset),
		.req   (reg_req),
		.wr    (reg_wr),
		.addr  (reg_addr),
		.wide  (reg_wide),
		.wdata (reg_wdata),
		.half  (half)
	);

	// Half access qualifiers
	wire half_wr = half.valid && half.wr && half.mapped;
	wire half_rd = half.valid && !half.wr && half.mapped;

	// Per pin: mode decode, next level, drive and read selection
	genvar i;
	generate
		for (i = 0; i < PPLV_PINS; i++)
		begin : g_pin
			localparam bit IS_HIGH = (i >= PPLV_HALF_W);
			localparam int LANE    = i % PPLV_HALF_W;
			// General output only when direction is output and function is off
			assign gpo[i] = dir_bits[i] && !func_bits[i];
			assign bus_wr_bit[i] = half_wr && (half.high == IS_HIGH);
			// Set beats clear beats a level write; all need a general output
			assign level_nxt[i] =
				(gpo[i] && drive_high_pulse[i]) ? 1'b1 :
				(gpo[i] && drive_low_pulse[i])  ? 1'b0 :
				(gpo[i] && bus_wr_bit[i])       ? half.data[LANE] :
				level_r[i];
			// Interface function owns the pin; direction then has no say
			assign pin_out_nxt[i] = func_bits[i] ? alt_out[i] : level_r[i];
			assign pin_oe_nxt[i]  = func_bits[i] ? alt_oe[i]  : dir_bits[i];
			// General outputs read the programmed level, everything else the live pin
			assign read_all[i] = gpo[i] ? level_r[i] : pin_sync_r[i];
		end
	endgenerate

	// Read data of the current half, placed by lane
	wire [15:0] read_half = half.high ? read_all[31:16] : read_all[15:0];
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (half.valid)
		begin
			if (!half_rd)
				rdata_nxt = PPLV_ZERO32;   // Writes and unmapped reads answer zero
			else if (half.upper_lane)
				rdata_nxt = {read_half, rdata_r[15:0]};
			else
				rdata_nxt = {PPLV_ZERO16, read_half};
		end
	end

	// Pin synchroniser; the first stage feeds only the second
	always_ff @(posedge clk)
	begin
		pin_meta_r <= pin_in;
		pin_sync_r <= pin_meta_r;
	end

	// Level store; reset keeps the pad drive known, and a general output reads the reset level until written
	always_ff @(posedge clk)
	begin
		if (reset)
			level_r <= PPLV_LEVEL_RST;
		else
			level_r <= level_nxt;
	end

	// Pad drive, registered so every output comes from a flop
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pin_out_r <= PPLV_LEVEL_RST;
			pin_oe_r  <= PPLV_OE_RST;
			pull_en_r <= PPLV_PULL_RST;
		end
		else
		begin
			pin_out_r <= pin_out_nxt;
			pin_oe_r  <= pin_oe_nxt;
			pull_en_r <= ~pin_oe_nxt;    // Pull only while the block does not drive the pin
		end
	end

	// Bus answer
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rdata_r <= PPLV_ZERO32;
			ack_r   <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			ack_r   <= half.valid && half.last;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_ack   = ack_r;
	assign pin_out   = pin_out_r;
	assign pin_oe    = pin_oe_r;
	assign pull_en   = pull_en_r;

	// Checks; one clock only, so default clocking and disable serve them all
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Read data lands in the low lane, except the second half of a wide read, which takes the upper lane
	a_read_low_map: assert property (
		half_rd && !half.high && !half.upper_lane
		|=> rdata_r == {PPLV_ZERO16, $past(read_all[15:0])})
		else $error("low half read misplaced");
	a_read_high_narrow: assert property (
		half_rd && half.high && !half.upper_lane
		|=> rdata_r == {PPLV_ZERO16, $past(read_all[31:16])})
		else $error("high half read not in low lane");
	a_read_high_lane: assert property (
		half_rd && half.upper_lane
		|=> rdata_r[31:16] == $past(read_all[31:16]))
		else $error("high half of wide read misplaced");

	// Read value per pin, judged on the bus data so a wrong select shows up
	a_read_gpo_level: assert property (
		half_rd && !half.high && !half.upper_lane
		|=> ((rdata_r[15:0] ^ $past(level_r[15:0])) & $past(gpo[15:0])) == PPLV_ZERO16)
		else $error("output pin read not programmed level");
	a_read_gpo_upper: assert property (
		half_rd && half.upper_lane
		|=> ((rdata_r[31:16] ^ $past(level_r[31:16])) & $past(gpo[31:16])) == PPLV_ZERO16)
		else $error("upper output pin read not programmed level");
	a_read_pin_state: assert property (
		half_rd && !half.high && !half.upper_lane
		|=> ((rdata_r[15:0] ^ $past(pin_sync_r[15:0])) & ~$past(gpo[15:0])) == PPLV_ZERO16)
		else $error("non output pin read not pin state");
	a_read_pin_upper: assert property (
		half_rd && half.high && !half.upper_lane
		|=> ((rdata_r[15:0] ^ $past(pin_sync_r[31:16])) & ~$past(gpo[31:16])) == PPLV_ZERO16)
		else $error("upper non output pin read not pin state");

	// Unmapped halves answer zero and store nothing
	a_unmapped_zero: assert property (
		half.valid && !half.mapped |=> rdata_r == PPLV_ZERO32)
		else $error("unmapped access returned data");
	a_unmapped_no_write: assert property (
		half.valid && !half.mapped && !(|drive_high_pulse) && !(|drive_low_pulse)
		|=> level_r == $past(level_r))
		else $error("unmapped access changed a level");

	// Level writes, set and clear on general outputs
	a_write_sets_level: assert property (
		half_wr && !half.high
		&& (gpo[15:0] & ~drive_high_pulse[15:0] & ~drive_low_pulse[15:0]) == 16'hffff
		|=> level_r[15:0] == $past(half.data) ##1 pin_out_r[15:0] == $past(level_r[15:0], 1))
		else $error("level write did not reach pins");
	a_write_high_half: assert property (
		half_wr && half.high
		&& (gpo[31:16] & ~drive_high_pulse[31:16] & ~drive_low_pulse[31:16]) == 16'hffff
		|=> level_r[31:16] == $past(half.data))
		else $error("high half write did not reach upper pins");
	a_set_wins: assert property (
		|(drive_high_pulse & gpo)
		|=> (level_r & $past(drive_high_pulse & gpo)) == $past(drive_high_pulse & gpo))
		else $error("set strobe did not drive high");
	a_clear_low: assert property (
		|(drive_low_pulse & ~drive_high_pulse & gpo)
		|=> (level_r & $past(drive_low_pulse & ~drive_high_pulse & gpo)) == PPLV_ZERO32)
		else $error("clear strobe did not drive low");
	a_input_untouched: assert property (
		##1 ((level_r ^ $past(level_r)) & ~$past(gpo)) == PPLV_ZERO32)
		else $error("level changed on non output pin");

	// Pad drive follows the mode one cycle late
	a_oe_follows_mode: assert property (
		##1 pin_oe_r == (($past(func_bits) & $past(alt_oe))
			| (~$past(func_bits) & $past(dir_bits))))
		else $error("output enable not from direction or function");
	a_func_owns_pin: assert property (
		##1 (pin_out_r & $past(func_bits)) == ($past(alt_out) & $past(func_bits)))
		else $error("function pin not driven by interface");
	a_pin_follows_level: assert property (
		##1 (pin_out_r & ~$past(func_bits)) == ($past(level_r) & ~$past(func_bits)))
		else $error("general pin not driven from level");
	a_pull_when_idle: assert property (
		pull_en_r == ~pin_oe_r)
		else $error("pull termination on while driving");
	a_reset_inputs: assert property (@(posedge clk) $past(reset)
		|-> pin_oe == PPLV_OE_RST && pull_en == PPLV_PULL_RST)
		else $error("pins not inputs with pull after reset");

	// One acknowledge per request, right after its last half
	a_ack_after_last: assert property (half.valid && half.last |=> reg_ack ##1 !reg_ack)
		else $error("acknowledge missing or stuck");
	a_ack_needs_half: assert property (
		reg_ack |-> $past(half.valid && half.last))
		else $error("acknowledge without a finished half");

	// Main scenarios
	c_wide_read: cover property (half_rd && half.upper_lane ##1 reg_ack);
	c_narrow_write: cover property (half_wr && !half.high && |gpo[15:0] ##1 reg_ack);
	c_set_over_write: cover property (half_wr && |(drive_high_pulse & gpo));
	c_unmapped: cover property (half.valid && !half.mapped);
	c_func_read: cover property (half_rd && |func_bits ##1 reg_ack);

endmodule : pplv_top

/* hw/pplv_pkg.sv */
// Constants and carriers shared by the pin level access block.
// Assumes a single system clock domain and a native 16/32-bit register port.
package pplv_pkg;

	// Port geometry
	localparam int PPLV_PINS   = 32;
	localparam int PPLV_HALF_W = 16;

	// Byte offsets inside the memory mapped configuration region
	localparam logic [11:0] PPLV_OFF_LOW  = 12'h0c30;
	localparam logic [11:0] PPLV_OFF_HIGH = 12'h0c32;

	// Reset values of the control state
	localparam logic [31:0] PPLV_LEVEL_RST = 32'h0000_0000;
	localparam logic [31:0] PPLV_OE_RST    = 32'h0000_0000;
	localparam logic [31:0] PPLV_PULL_RST  = 32'hffff_ffff;
	localparam logic [31:0] PPLV_ZERO32    = 32'h0000_0000;
	localparam logic [15:0] PPLV_ZERO16    = 16'h0000;

	// Splitter states, one-hot
	typedef enum logic [2:0] {
		PPLV_IDLE   = 3'b001,
		PPLV_FIRST  = 3'b010,
		PPLV_SECOND = 3'b100
	} pplv_state_e;

	// One 16-bit half access handed from the splitter to the register file
	typedef struct packed {
		logic        valid;
		logic        wr;
		logic        high;
		logic        upper_lane;
		logic        mapped;
		logic        last;
		logic [15:0] data;
	} pplv_half_s;

endpackage : pplv_pkg

/* hw/pplv_split.sv */
// Splits each register request into one or two 16-bit half accesses.
// Assumes the requester waits for the acknowledge before the next request.
`timescale 1ns/1ps

module pplv_split
	import pplv_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        req,
	input  wire logic        wr,
	input  wire logic [11:0] addr,
	input  wire logic        wide,
	input  wire logic [31:0] wdata,
	output pplv_half_s       half
);

	pplv_state_e state_r;
	pplv_state_e state_nxt;
	logic        wr_r;
	logic [11:0] addr_r;
	logic        wide_r;
	logic [31:0] wdata_r;

	// Decode of the held request
	wire take      = req && (state_r == PPLV_IDLE);
	wire in_first  = (state_r == PPLV_FIRST);
	wire in_second = (state_r == PPLV_SECOND);
	wire hit_low   = (addr_r == PPLV_OFF_LOW);
	wire hit_high  = (addr_r == PPLV_OFF_HIGH);

	// Next state: a wide access takes the low half first, then the high one
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			PPLV_IDLE:   if (take) state_nxt = PPLV_FIRST;
			PPLV_FIRST:  state_nxt = wide_r ? PPLV_SECOND : PPLV_IDLE;
			PPLV_SECOND: state_nxt = PPLV_IDLE;
			default:     state_nxt = PPLV_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (reset)
			state_r <= PPLV_IDLE;
		else
			state_r <= state_nxt;
	end

	// Request capture; data path needs no reset
	always_ff @(posedge clk)
	begin
		if (take)
		begin
			wr_r    <= wr;
			addr_r  <= addr;
			wide_r  <= wide;
			wdata_r <= wdata;
		end
	end

	// Half access presented to the register file
	assign half.valid      = in_first || in_second;
	assign half.wr         = wr_r;
	assign half.high       = in_second || (in_first && !wide_r && hit_high);
	assign half.upper_lane = in_second;
	assign half.mapped     = wide_r ? hit_low : (hit_low || hit_high);
	assign half.last       = in_second || (in_first && !wide_r);
	assign half.data       = in_second ? wdata_r[31:16] : wdata_r[15:0];

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_wide_low_first: assert property (
		take && wide |=> half.valid && !half.high && !half.last
		##1 half.valid && half.high && half.last)
		else $error("wide access not split low then high");
	a_narrow_single: assert property (
		take && !wide |=> half.valid && half.last ##1 !half.valid)
		else $error("narrow access not a single half");

endmodule : pplv_split

/* dv/pplv_pads.sv */
// Pad model for the 32 port pins: resolves each pin from the block and the bench.
// Assumes the pull termination pulls up and that the bench never fights the block.
`timescale 1ns/1ps

module pplv_pads
	import pplv_pkg::*;
(
	input  wire logic [31:0] pin_out,
	input  wire logic [31:0] pin_oe,
	input  wire logic [31:0] pull_en,
	input  wire logic [31:0] ext_val,
	input  wire logic [31:0] ext_oe,
	output logic      [31:0] pin_in
);
	// Block drive wins, then the bench; an idle pin rests at the pull level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
		| (~pin_oe & ~ext_oe & pull_en);
endmodule : pplv_pads

/* dv/pplv_top_tb_top.sv */
// Bench for the pin level block: request tasks on the native port, pad model.
// Assumes one 10 MHz clock; sibling register outputs are driven from here.
`timescale 1ns/1ps

module pplv_top_tb_top
	import pplv_pkg::*;
;
	logic        clk              = 1'b0;
	logic        reset            = 1'b1;
	logic        reg_req          = 1'b0;
	logic        reg_wr           = 1'b0;
	logic        reg_wide         = 1'b0;
	logic [11:0] reg_addr         = PPLV_OFF_LOW;
	logic [31:0] reg_wdata        = PPLV_ZERO32;
	logic [31:0] dir_bits         = PPLV_ZERO32;
	logic [31:0] func_bits        = PPLV_ZERO32;
	logic [31:0] drive_high_pulse = PPLV_ZERO32;
	logic [31:0] drive_low_pulse  = PPLV_ZERO32;
	logic [31:0] alt_out          = 32'hff00_0000;
	logic [31:0] alt_oe           = 32'hf0f0_0000;
	logic [31:0] ext_val          = PPLV_ZERO32;
	logic [31:0] ext_oe           = PPLV_ZERO32;
	logic [31:0] reg_rdata;
	logic [31:0] pin_out;
	logic [31:0] pin_oe;
	logic [31:0] pull_en;
	logic [31:0] pin_in;
	logic [31:0] rd;
	logic        reg_ack;
	int          err_total        = 0;
	int          cmp_count        = 0;

	// 100 ns period
	always #50 clk = ~clk;

	pplv_top DUT (.clk(clk), .reset(reset), .reg_req(reg_req), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wide(reg_wide), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack), .dir_bits(dir_bits),
		.func_bits(func_bits), .drive_high_pulse(drive_high_pulse),
		.drive_low_pulse(drive_low_pulse), .alt_out(alt_out), .alt_oe(alt_oe),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en));

	pplv_pads pads (.pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
		.ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));

	task automatic end_sim();
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	// One request; ack is awaited under a bound and its latency is compared
	task automatic acc(input logic w, input logic [11:0] a, input logic wd,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		reg_req   <= 1'b1;
		reg_wr    <= w;
		reg_addr  <= a;
		reg_wide  <= wd;
		reg_wdata <= d;
		@(posedge clk);
		reg_req <= 1'b0;
		for (k = 1; k < 9 && reg_ack !== 1'b1; k++)
			@(negedge clk);
		if (k == 9)
		begin
			err_total++;
			end_sim();
		end
		chk(32'(k), wd ? 32'h0000_0004 : 32'h0000_0003);
		rd = reg_rdata;
	endtask : acc

	// Sibling settings and bench pad drive change together, then pins settle
	task automatic cfg(input logic [31:0] d, input logic [31:0] f,
		input logic [31:0] eo, input logic [31:0] ev);
		@(posedge clk);
		dir_bits  <= d;
		func_bits <= f;
		ext_oe    <= eo;
		ext_val   <= ev;
		tick(4);
	endtask : cfg

	// Main sequence; pins are idle and pulled up until outputs are enabled
	initial
	begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		tick(1);
		chk(pin_oe, PPLV_ZERO32);
		chk(pull_en, 32'hffff_ffff);
		acc(1'b0, PPLV_OFF_LOW, 1'b1, PPLV_ZERO32);
		chk(rd, 32'hffff_ffff);
		cfg(32'hffff_ffff, PPLV_ZERO32, PPLV_ZERO32, PPLV_ZERO32);
		acc(1'b1, PPLV_OFF_LOW, 1'b1, 32'h1234_5678);
		tick(2);
		chk(pin_out, 32'h1234_5678);
		chk(pin_oe, 32'hffff_ffff);
		acc(1'b1, PPLV_OFF_HIGH, 1'b0, 32'h0000_a5a5);
		acc(1'b0, PPLV_OFF_LOW, 1'b1, PPLV_ZERO32);
		chk(rd, 32'ha5a5_5678);
		acc(1'b0, PPLV_OFF_HIGH, 1'b0, PPLV_ZERO32);
		chk(rd, 32'h0000_a5a5);
		// Bit 1 gets set and clear together: set must win
		@(posedge clk);
		drive_high_pulse <= 32'h0000_0003;
		drive_low_pulse  <= 32'h8000_0002;
		@(posedge clk);
		drive_high_pulse <= PPLV_ZERO32;
		drive_low_pulse  <= PPLV_ZERO32;
		tick(2);
		chk(pin_out, 32'h25a5_567b);
		acc(1'b0, PPLV_OFF_LOW, 1'b1, PPLV_ZERO32);
		chk(rd, 32'h25a5_567b);
		// Low half as inputs driven from outside; a level write must not stick
		cfg(32'hffff_0000, PPLV_ZERO32, 32'h0000_ffff, 32'h0000_3c3c);
		chk(pin_oe, 32'hffff_0000);
		chk(pull_en, 32'h0000_ffff);
		acc(1'b1, PPLV_OFF_LOW, 1'b0, PPLV_ZERO32);
		acc(1'b0, PPLV_OFF_LOW, 1'b0, PPLV_ZERO32);
		chk(rd, 32'h0000_3c3c);
		cfg(32'hffff_ffff, PPLV_ZERO32, PPLV_ZERO32, PPLV_ZERO32);
		chk(pin_out, 32'h25a5_567b);
		// High half on interface function, direction left at output
		cfg(32'hffff_ffff, 32'hffff_0000, 32'h0f0f_0000, 32'h0a0a_0000);
		chk(pin_oe, 32'hf0f0_ffff);
		chk(pin_out, 32'hff00_567b);
		acc(1'b1, PPLV_OFF_HIGH, 1'b0, PPLV_ZERO32);
		acc(1'b0, PPLV_OFF_HIGH, 1'b0, PPLV_ZERO32);
		chk(rd, 32'h0000_fa0a);
		// Wide access at the high offset and an unmapped offset are ignored
		cfg(32'hffff_ffff, PPLV_ZERO32, PPLV_ZERO32, PPLV_ZERO32);
		acc(1'b1, PPLV_OFF_HIGH, 1'b1, 32'hffff_ffff);
		acc(1'b0, 12'h0c34, 1'b0, PPLV_ZERO32);
		chk(rd, PPLV_ZERO32);
		tick(1);
		chk(pin_out, 32'h25a5_567b);
		end_sim();
	end
endmodule : pplv_top_tb_top
